// file: design/tpa_regs.vh
// Register offsets, field positions and constants for the timer accumulator block
// How it works
// - Overflow flag sets on count wrap
// - Overflow flag and enable raise request
// - Write one clears overflow flag
// - Event mode edge sets input flag
// - Gate trailing edge sets input flag
// - Input flag and enable raise request
// - Write one clears input flag
// - Fast clear: count access clears flags
// - Sixteen-bit count, software readable and writable
// - Accumulator input synchronised before counting
// - Port data latched, driven when output
// - Read pin when input, latch when output
// - Timer-driven pin ignores port data writes
// - Reset clears all direction bits
// - Direction bit one means output
// - Sixteen-bit counter, four channels, one accumulator
// - Prescaler divides by one to 128
// - Mode bit selects event or gated
// - Edge bit selects rising or falling
// - Gate level gates divide-by-64 clock
`ifndef TPA_REGS_VH
`define TPA_REGS_VH

`define TPA_OFF_SYSCTL1     8'h00
`define TPA_OFF_SYSCTL2     8'h04
`define TPA_OFF_ACCCTL      8'h08
`define TPA_OFF_ACCFLG      8'h0C
`define TPA_OFF_ACCCNT      8'h10
`define TPA_OFF_PORTDAT     8'h14
`define TPA_OFF_PORTDIR     8'h18
`define TPA_OFF_COUNTER     8'h1C
`define TPA_OFF_CHANSEL     8'h20
`define TPA_OFF_CHAN0       8'h24

`define TPA_BIT_TIMER_EN    7
`define TPA_BIT_FAST_CLR    4
`define TPA_BIT_ACC_EN      6
`define TPA_BIT_ACC_MODE    5
`define TPA_BIT_ACC_EDGE    4
`define TPA_BIT_OVF_IE      1
`define TPA_BIT_IN_IE       0
`define TPA_BIT_OVF_FLAG    1
`define TPA_BIT_IN_FLAG     0

`define TPA_RST_BYTE        8'h00
`define TPA_RST_NIBBLE      4'h0
`define TPA_RST_WORD        16'h0000
`define TPA_CNT_MAX         16'hFFFF
`define TPA_GATE_DIV_MASK   7'h3F

`endif

// file: design/tpa_top.v
// Pulse accumulator, four-channel timer, prescaler and port logic behind APB
`timescale 1ns/1ns
`default_nettype none
`include "tpa_regs.vh"

module tpa_top #(
  parameter CHANNELS = 4,
  parameter CNT_W    = 16
) (
  input  wire                clk,
  input  wire                reset,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [CHANNELS-1:0] portPinIn,
  output reg  [CHANNELS-1:0] portPinOut,
  output reg  [CHANNELS-1:0] portPinOe,
  output reg                 overflowIrq,
  output reg                 inputIrq
);

  // Mask of prescaler bits that must be all ones for a tick
  function [6:0] tpaPrescaleMask;
    input [2:0] sel;
    begin
      tpaPrescaleMask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  // Register-offset match used by the write decode; the read mux uses a case
  function tpaHit;
    input [7:0] addr;
    input [7:0] off;
    begin
      tpaHit = (addr == off);
    end
  endfunction

  reg               timerEn_q;
  reg               fastClr_q;
  reg  [2:0]        prescaleSel_q;
  reg               accEnable_q;
  reg               accMode_q;
  reg               accEdge_q;
  reg               ovfIe_q;
  reg               inIe_q;
  reg               ovfFlag_q;
  reg               inFlag_q;
  reg  [CNT_W-1:0]  accCount_q;
  reg  [CHANNELS-1:0] portLatch_q;
  reg  [CHANNELS-1:0] portDir_q;
  reg  [CHANNELS-1:0] chanSel_q;
  reg  [CHANNELS-1:0] ocLevel_q;
  reg  [CNT_W-1:0]  mainCount_q;
  reg  [6:0]        prescale_q;
  reg  [CHANNELS-1:0] pinMeta_q;
  reg  [CHANNELS-1:0] pinSync_q;
  reg  [CHANNELS-1:0] pinLast_q;
  reg  [CNT_W-1:0]  chanReg_q [0:CHANNELS-1];

  wire              access;
  wire              wrStrobe;
  wire              rdStrobe;
  wire              prescaleTick;
  wire              gateTick;
  wire              accIn;
  wire              accRise;
  wire              accFall;
  wire              accActiveEdge;
  wire              gateLevel;
  wire              gateTrail;
  wire              accInc;
  wire              accWrite;
  wire              countTouched;
  wire              setOvf;
  wire              setIn;
  wire [CHANNELS-1:0] ocDrive;
  reg  [31:0]       readData;
  reg               addrValid;
  integer           i;

  // Access phase, answered once; pready drops for a cycle after each answer
  assign access   = psel & penable & ~pready;
  assign wrStrobe = access & pwrite;
  assign rdStrobe = access & ~pwrite;

  // Prescaler runs only while the timer is enabled
  // selectable power-of-two divide
  assign prescaleTick = timerEn_q &
    ((prescale_q & tpaPrescaleMask(prescaleSel_q)) == tpaPrescaleMask(prescaleSel_q));
  assign gateTick = timerEn_q & ((prescale_q & `TPA_GATE_DIV_MASK) == `TPA_GATE_DIV_MASK);

  // Accumulator input shares the channel 3 pin; edges seen on synchronised copy
  // count from synchronised input only
  assign accIn   = pinSync_q[CHANNELS-1];
  assign accRise = accIn & ~pinLast_q[CHANNELS-1];
  assign accFall = ~accIn & pinLast_q[CHANNELS-1];

  // edge bit picks rising or falling
  assign accActiveEdge = accEdge_q ? accRise : accFall;
  // edge bit one means low gate level
  assign gateLevel = accEdge_q ? ~accIn : accIn;
  // trailing edge of active gate level
  assign gateTrail = accEdge_q ? accRise : accFall;

  // mode bit selects event or gated counting
  assign accInc = accEnable_q & (accMode_q ? (gateTick & gateLevel) : accActiveEdge);

  assign accWrite     = wrStrobe & tpaHit(paddr, `TPA_OFF_ACCCNT);
  // any count access triggers fast clear
  assign countTouched = access & tpaHit(paddr, `TPA_OFF_ACCCNT) & fastClr_q;
  // wrap from all ones to zero
  assign setOvf = accInc & ~accWrite & (accCount_q == `TPA_CNT_MAX);
  // selected edge sets input flag in event mode
  assign setIn  = accEnable_q & (accMode_q ? gateTrail : accActiveEdge);

  // Output-compare channels take over their pins while the timer runs
  assign ocDrive = chanSel_q & {CHANNELS{timerEn_q}};

  // Read mux and decode of mapped offsets
  always @*
  begin
    readData  = 32'h0000_0000;
    addrValid = 1'b1;
    case (paddr)
      `TPA_OFF_SYSCTL1:
      begin
        readData[`TPA_BIT_TIMER_EN] = timerEn_q;
        readData[`TPA_BIT_FAST_CLR] = fastClr_q;
      end
      `TPA_OFF_SYSCTL2: readData[2:0] = prescaleSel_q;
      `TPA_OFF_ACCCTL:
      begin
        readData[`TPA_BIT_ACC_EN]   = accEnable_q;
        readData[`TPA_BIT_ACC_MODE] = accMode_q;
        readData[`TPA_BIT_ACC_EDGE] = accEdge_q;
        readData[`TPA_BIT_OVF_IE]   = ovfIe_q;
        readData[`TPA_BIT_IN_IE]    = inIe_q;
      end
      `TPA_OFF_ACCFLG:
      begin
        readData[`TPA_BIT_OVF_FLAG] = ovfFlag_q;
        readData[`TPA_BIT_IN_FLAG]  = inFlag_q;
      end
      `TPA_OFF_ACCCNT:  readData[CNT_W-1:0] = accCount_q;
      // pin level for inputs, latch for outputs
      `TPA_OFF_PORTDAT: readData[CHANNELS-1:0] = (portDir_q & portLatch_q) |
                                                 (~portDir_q & pinSync_q);
      `TPA_OFF_PORTDIR: readData[CHANNELS-1:0] = portDir_q;
      `TPA_OFF_COUNTER: readData[CNT_W-1:0] = mainCount_q;
      `TPA_OFF_CHANSEL: readData[CHANNELS-1:0] = chanSel_q;
      default:
      begin
        addrValid = 1'b0;
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
          if (paddr == `TPA_OFF_CHAN0 + 8'h04 * i[7:0])
          begin
            readData[CNT_W-1:0] = chanReg_q[i];
            addrValid = 1'b1;
          end
        end
      end
    endcase
  end

  // APB answer: one wait cycle, then a one-cycle pready with registered data
  always @(posedge clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~addrValid;
      if (rdStrobe)
        prdata <= addrValid ? readData : 32'h0000_0000;
    end
  end

  // Control registers; reserved bits are simply not stored
  always @(posedge clk)
  begin
    if (reset)
    begin
      timerEn_q     <= 1'b0;
      fastClr_q     <= 1'b0;
      prescaleSel_q <= 3'h0;
      accEnable_q   <= 1'b0;
      accMode_q     <= 1'b0;
      accEdge_q     <= 1'b0;
      ovfIe_q       <= 1'b0;
      inIe_q        <= 1'b0;
      chanSel_q     <= `TPA_RST_NIBBLE;
    end
    else if (wrStrobe)
    begin
      if (tpaHit(paddr, `TPA_OFF_SYSCTL1))
      begin
        timerEn_q <= pwdata[`TPA_BIT_TIMER_EN];
        fastClr_q <= pwdata[`TPA_BIT_FAST_CLR];
      end
      if (tpaHit(paddr, `TPA_OFF_SYSCTL2))
        prescaleSel_q <= pwdata[2:0];
      if (tpaHit(paddr, `TPA_OFF_ACCCTL))
      begin
        accEnable_q <= pwdata[`TPA_BIT_ACC_EN];
        accMode_q   <= pwdata[`TPA_BIT_ACC_MODE];
        accEdge_q   <= pwdata[`TPA_BIT_ACC_EDGE];
        ovfIe_q     <= pwdata[`TPA_BIT_OVF_IE];
        inIe_q      <= pwdata[`TPA_BIT_IN_IE];
      end
      if (tpaHit(paddr, `TPA_OFF_CHANSEL))
        chanSel_q <= pwdata[CHANNELS-1:0];
    end
  end

  // Flags: hardware set wins over write-one or fast clear in the same cycle
  always @(posedge clk)
  begin
    if (reset)
    begin
      ovfFlag_q <= 1'b0;
      inFlag_q  <= 1'b0;
    end
    else
    begin
      if (setOvf)
        ovfFlag_q <= 1'b1;
      else if (countTouched ||
               (wrStrobe && tpaHit(paddr, `TPA_OFF_ACCFLG) && pwdata[`TPA_BIT_OVF_FLAG]))
        ovfFlag_q <= 1'b0;
      if (setIn)
        inFlag_q <= 1'b1;
      else if (countTouched ||
               (wrStrobe && tpaHit(paddr, `TPA_OFF_ACCFLG) && pwdata[`TPA_BIT_IN_FLAG]))
        inFlag_q <= 1'b0;
    end
  end

  // Accumulator count; a software write beats a same-cycle increment
  always @(posedge clk)
  begin
    if (reset)
      accCount_q <= `TPA_RST_WORD;
    else if (accWrite)
      accCount_q <= pwdata[CNT_W-1:0];
    else if (accInc)
      accCount_q <= accCount_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Interrupt requests as registered levels
  always @(posedge clk)
  begin
    if (reset)
    begin
      overflowIrq <= 1'b0;
      inputIrq    <= 1'b0;
    end
    else
    begin
      // overflow request while flag and enable
      overflowIrq <= ovfFlag_q & ovfIe_q;
      // input request while flag and enable
      inputIrq    <= inFlag_q & inIe_q;
    end
  end

  // Port latch and direction
  always @(posedge clk)
  begin
    if (reset)
    begin
      portLatch_q <= `TPA_RST_NIBBLE;
      portDir_q   <= `TPA_RST_NIBBLE;
    end
    else if (wrStrobe)
    begin
      if (tpaHit(paddr, `TPA_OFF_PORTDAT))
        portLatch_q <= pwdata[CHANNELS-1:0];
      if (tpaHit(paddr, `TPA_OFF_PORTDIR))
        portDir_q <= pwdata[CHANNELS-1:0];
    end
  end

  // Pin drive: compare output overrides direction, latch kept for later
  always @(posedge clk)
  begin
    if (reset)
    begin
      portPinOut <= `TPA_RST_NIBBLE;
      portPinOe  <= `TPA_RST_NIBBLE;
    end
    else
    begin
      portPinOut <= (ocDrive & ocLevel_q) | (~ocDrive & portLatch_q);
      portPinOe  <= ocDrive | portDir_q;
    end
  end

  // Prescaler and free-running main counter
  always @(posedge clk)
  begin
    if (reset)
    begin
      prescale_q  <= 7'h00;
      mainCount_q <= `TPA_RST_WORD;
    end
    else if (timerEn_q)
    begin
      prescale_q <= prescale_q + 7'h01;
      if (prescaleTick)
        mainCount_q <= mainCount_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Per-channel synchroniser, capture and compare
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : gChan
      // Two-flop synchroniser plus an edge-detect stage; only the first stage is never looked at
      always @(posedge clk)
      begin
        if (reset)
        begin
          pinMeta_q[ch] <= 1'b0;
          pinSync_q[ch] <= 1'b0;
          pinLast_q[ch] <= 1'b0;
        end
        else
        begin
          pinMeta_q[ch] <= portPinIn[ch];
          pinSync_q[ch] <= pinMeta_q[ch];
          pinLast_q[ch] <= pinSync_q[ch];
        end
      end

      always @(posedge clk)
      begin
        if (reset)
        begin
          chanReg_q[ch] <= `TPA_RST_WORD;
          ocLevel_q[ch] <= 1'b0;
        end
        else if (chanSel_q[ch])
        begin
          if (wrStrobe && paddr == `TPA_OFF_CHAN0 + 8'h04 * ch)
            chanReg_q[ch] <= pwdata[CNT_W-1:0];
          // Compare match toggles the pin
          if (prescaleTick && mainCount_q == chanReg_q[ch])
            ocLevel_q[ch] <= ~ocLevel_q[ch];
        end
        // Capture on rising edge, only while the pin is an input
        else if (timerEn_q && !portDir_q[ch] && pinSync_q[ch] && !pinLast_q[ch])
          chanReg_q[ch] <= mainCount_q;
      end
    end
  endgenerate

endmodule // tpa_top

`default_nettype wire

// file: verification/tpa_pin_model.sv
// Far-side model: outside level source resolved against the port drivers
`timescale 1ns/1ns
`default_nettype none
module tpa_pin_model (
  input  wire logic [3:0] extLevel,
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  output logic      [3:0] pinLevel
);
  // driver wins
  // Outside source holds each line the block has released
  assign pinLevel = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule // tpa_pin_model
`default_nettype wire

// file: verification/tpa_top_checker.sv
// Port-level assertions for the timer accumulator block
`timescale 1ns/1ns
`default_nettype none
`include "tpa_regs.vh"
module tpa_top_checker #(
  parameter CHANNELS = 4
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [CHANNELS-1:0] portPinIn,
  input wire logic [CHANNELS-1:0] portPinOut,
  input wire logic [CHANNELS-1:0] portPinOe,
  input wire logic                overflowIrq,
  input wire logic                inputIrq
);
  logic            timerOn_q;
  logic            fastClr_q;
  wire logic [3:0] wLo = pwdata[3:0];
  wire logic       wb0 = pwdata[0];
  wire logic       wb1 = pwdata[1];
  wire logic       acc = psel && penable && pready;
  wire logic       wr  = acc && pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow enables; timer-driven pins void the port checks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timerOn_q <= 1'h0;
      fastClr_q <= 1'h0;
    end
    else if (wr && paddr == `TPA_OFF_SYSCTL1)
    begin
      timerOn_q <= pwdata[`TPA_BIT_TIMER_EN];
      fastClr_q <= pwdata[`TPA_BIT_FAST_CLR];
    end
  end
  property p_wait;
    psel && $rose(penable) |=> pready ##1 !pready;
  endproperty
  a_wait: assert property (p_wait) else $error("bad answer timing");
  property p_rst;
    $fell(reset) |-> portPinOe == '0 && !overflowIrq && !inputIrq;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs after reset");
  property p_dir;
    wr && paddr == `TPA_OFF_PORTDIR && !timerOn_q |=> portPinOe == $past(wLo);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_dat;
    wr && paddr == `TPA_OFF_PORTDAT && !timerOn_q
      |=> (portPinOut & portPinOe) == ($past(wLo) & portPinOe);
  endproperty
  a_dat: assert property (p_dat) else $error("output pins miss latch");
  property p_ien;
    wr && paddr == `TPA_OFF_ACCCTL
      |=> (!inputIrq || $past(wb0)) && (!overflowIrq || $past(wb1));
  endproperty
  a_ien: assert property (p_ien) else $error("request while disabled");
  property p_w1c;
    wr && paddr == `TPA_OFF_ACCFLG
      |=> (!inputIrq || !$past(wb0)) && (!overflowIrq || !$past(wb1));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag survived clear");
  property p_fast;
    acc && paddr == `TPA_OFF_ACCCNT && fastClr_q |=> !inputIrq && !overflowIrq;
  endproperty
  a_fast: assert property (p_fast) else $error("fast clear missed");
  property p_cnt;
    acc && !pwrite && paddr == `TPA_OFF_ACCCNT |-> prdata[31:16] == 16'h0000;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count wider than 16 bits");
endmodule // tpa_top_checker
bind tpa_top tpa_top_checker #(.CHANNELS(CHANNELS)) i_tpa_top_checker (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .portPinIn(portPinIn), .portPinOut(portPinOut),
  .portPinOe(portPinOe), .overflowIrq(overflowIrq), .inputIrq(inputIrq));
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the timer accumulator block
`timescale 1ns/1ns
`default_nettype none
`include "tpa_regs.vh"
module tb_top;
  localparam [7:0] FLG = `TPA_OFF_ACCFLG;
  localparam [7:0] CNT = `TPA_OFF_ACCCNT;
  localparam [7:0] CTL = `TPA_OFF_ACCCTL;
  localparam [7:0] DAT = `TPA_OFF_PORTDAT;
  localparam [7:0] DIR = `TPA_OFF_PORTDIR;
  localparam [7:0] SC1 = `TPA_OFF_SYSCTL1;
  logic        clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, errS;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, r, seed = 32'h43;
  logic [3:0]  extLevel = 4'h5;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, overflowIrq, inputIrq;
  wire logic [3:0]  pinOut, pinOe, pinLevel;
  integer      n_errors = 0, total_checks = 0, mCnt, i, k;
  always #10 clk = ~clk;
  tpa_top i_tpa_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portPinIn(pinLevel), .portPinOut(pinOut), .portPinOe(pinOe),
    .overflowIrq(overflowIrq), .inputIrq(inputIrq));
  tpa_pin_model i_tpa_pin_model (.extLevel(extLevel), .pinOut(pinOut), .pinOe(pinOe),
    .pinLevel(pinLevel));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      n_errors = n_errors + 1;
    end
  endtask
  // Range compare; free-running dividers have unknown phase
  task chk_rng(input logic [31:0] got, input integer lo, input integer hi);
    total_checks = total_checks + 1;
    if ((got >= lo && got <= hi) !== 1'h1)
    begin
      $display("BAD %0t got %h exp %h", $time, got, lo);
      n_errors = n_errors + 1;
    end
  endtask
  // One APB transfer; request held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer t;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    t = 0;
    do
    begin
      @(posedge clk);
      t = t + 1;
    end
    while (pready !== 1'h1 && t < 16);
    if (pready !== 1'h1)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
    else
    begin
      rdat = prdata;
      errS = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  task pin3(input logic v);
    @(posedge clk);
    extLevel[3] <= v;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    rd(FLG, 0);
    rd(CNT, 0);
    rd(DIR, 0);
    rd(DAT, 5);
    rd(8'hFC, 0);
    chk(errS, 1);
    $display("test reset done");
    // Edge select: rising counts going up, falling coming down
    for (k = 1; k >= 0; k = k - 1)
    begin
      wr(CTL, 32'h40 | (k << 4));
      wr(CNT, 0);
      pin3(1'h1);
      rd(CNT, k);
      pin3(1'h0);
      rd(CNT, 1);
      rd(FLG, 1);
      wr(FLG, 1);
      rd(FLG, 0);
    end
    wr(CTL, 0);
    pin3(1'h1);
    pin3(1'h0);
    rd(CNT, 1);
    wr(CTL, 32'h51);
    wr(CNT, 0);
    mCnt = 0;
    r = rnd();
    for (i = 0; i <= r[2:0]; i = i + 1)
    begin
      pin3(1'h1);
      pin3(1'h0);
      mCnt = mCnt + 1;
    end
    rd(CNT, mCnt);
    chk(inputIrq, 1);
    $display("test edges done");
    wr(CTL, 32'h52);
    wr(CNT, 32'hFFFF);
    wr(FLG, 3);
    rd(FLG, 0);
    pin3(1'h1);
    pin3(1'h0);
    rd(CNT, 0);
    rd(FLG, 3);
    chk(overflowIrq, 1);
    wr(FLG, 1);
    rd(FLG, 2);
    wr(FLG, 2);
    rd(FLG, 0);
    wr(SC1, 32'h10);
    pin3(1'h1);
    pin3(1'h0);
    rd(CNT, 1);
    rd(FLG, 0);
    wr(SC1, 0);
    $display("test flags done");
    wr(CTL, 0);
    for (i = 0; i < 4; i = i + 1)
    begin
      r = rnd();
      extLevel <= r[11:8];
      wr(DAT, r[7:4]);
      wr(DIR, r[3:0]);
      repeat (3) @(posedge clk);
      rd(DAT, (r[7:4] & r[3:0]) | (r[11:8] & ~r[3:0]));
      chk(pinOe, r[3:0]);
      chk(pinOut & pinOe, r[7:4] & r[3:0]);
    end
    $display("test port done");
    // Gated mode: high level gates the divide-by-64 clock
    wr(DIR, 0);
    pin3(1'h0);
    wr(CTL, 32'h61);
    wr(CNT, 0);
    wr(SC1, 32'h80);
    pin3(1'h1);
    repeat (250) @(posedge clk);
    rd(FLG, 0);
    pin3(1'h0);
    apb(1'h0, CNT, 0);
    chk_rng(rdat, 3, 5);
    rd(FLG, 1);
    // Gated mode, edge bit set: low level gates, rising edge ends gate
    wr(CTL, 0);
    pin3(1'h1);
    wr(CTL, 32'h71);
    wr(CNT, 0);
    wr(FLG, 1);
    pin3(1'h0);
    repeat (250) @(posedge clk);
    pin3(1'h1);
    apb(1'h0, CNT, 0);
    chk_rng(rdat, 3, 5);
    rd(FLG, 1);
    for (k = 0; k < 8; k = k + 1)
    begin
      wr(`TPA_OFF_SYSCTL2, k);
      apb(1'h0, `TPA_OFF_COUNTER, 0);
      i = rdat;
      repeat (256) @(posedge clk);
      apb(1'h0, `TPA_OFF_COUNTER, 0);
      chk_rng((rdat - i) & 32'hFFFF, (260 >> k) - 1, (260 >> k) + 1);
    end
    $display("test timer done");
    // Compare pin ignores port writes; latch shows once released
    wr(SC1, 0);
    // Channel must be a compare channel before its register takes a write
    wr(`TPA_OFF_CHANSEL, 1);
    wr(`TPA_OFF_CHAN0, 32'hFFFF);
    wr(DIR, 1);
    wr(DAT, 0);
    wr(SC1, 32'h80);
    wr(DAT, 1);
    repeat (2) @(posedge clk);
    chk(pinOut[0], 0);
    wr(SC1, 0);
    repeat (2) @(posedge clk);
    chk(pinOut[0], 1);
    rd(DAT, {extLevel[3:1], 1'h1});
    $display("test compare done");
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
